// [rtl/scir_consts.vh]
// Functional notes
// [RULE_01] Register 7 writes hit extended reg when selected
// [RULE_02] Extended read swaps five read slots
// [RULE_03] Extended features persist until disabled or reset
// [RULE_04] Host writes zero to extended reserved bit
// [RULE_05] Complete-CRC bit delivers whole second CRC byte
// [RULE_06] Request pin deactivation: immediate or four clocks
// [RULE_07] Force line high drops transmit buffer writes
// [RULE_08] Auto RTS deasserts after closing flag
// [RULE_09] Auto END_OF_MESSAGE clears latch and presets CRC
// [RULE_10] Auto opening flag before frame data
// [RULE_11] One master interrupt register, both channels
// [RULE_12] Reset field decodes none, B, A, full
// [RULE_13] Reset disables channel, clears latches, modem high
// [RULE_14] Host waits four clocks after reset command
// [RULE_15] Vector read with soft ack acknowledges
// [RULE_16] Status position selects vector code bits
// [RULE_17] Master enable gates requests and chain output
// [RULE_18] Lower chain disable forces chain output low
// [RULE_19] No-vector bit keeps bus released
// [RULE_20] Vector includes status unless no-vector
// [RULE_21] CRC preset ones or zeros, ignored async
// [RULE_22] Encoding select, hardware reset gives NRZ
//
// Purpose: Constants of the serial control register bank
// Assumes: Register number in address bits 3..0, channel in bit 4
// Notes  : Definitions only
`ifndef SCIR_CONSTS_VH
`define SCIR_CONSTS_VH

// ----------------------------------------------------------------
// Register numbers
// ----------------------------------------------------------------
`define SCIR_AD_STAT0     4'h0
`define SCIR_AD_STAT1     4'h1
`define SCIR_AD_VEC       4'h2
`define SCIR_AD_RXP_PEND  4'h3
`define SCIR_AD_MODE      4'h4
`define SCIR_AD_TXP       4'h5
`define SCIR_AD_SYNC      4'h7
`define SCIR_AD_TXBUF     4'h8
`define SCIR_AD_MIC_RXPX  4'h9
`define SCIR_AD_MISC_ST10 4'ha
`define SCIR_AD_MISCX     4'hb
`define SCIR_AD_STAT13    4'hd
`define SCIR_AD_EXTF      4'he
`define SCIR_AD_SIE       4'hf

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SCIR_SIE_EXTSEL   0
`define SCIR_EXTF_RDEXT   6
`define SCIR_EXTF_CRCFULL 5
`define SCIR_EXTF_FORCEHI 3
`define SCIR_EXTF_AUTORTS 2
`define SCIR_EXTF_AUTOEOM 1
`define SCIR_EXTF_AUTOFLG 0
`define SCIR_EXTF_MASK    8'h7f
`define SCIR_MIC_RST_HI   7
`define SCIR_MIC_RST_LO   6
`define SCIR_MIC_SWACK    5
`define SCIR_MIC_STATHI   4
`define SCIR_MIC_MIE      3
`define SCIR_MIC_DLC      2
`define SCIR_MIC_NV       1
`define SCIR_MIC_VIS      0
`define SCIR_MIC_KEEP     8'h1c
`define SCIR_MIC_STORE    8'h3f
`define SCIR_TXP_DTR      7
`define SCIR_TXP_TXEN     3
`define SCIR_TXP_RTS      1
`define SCIR_RXP_RXEN     0
`define SCIR_MISC_PRESET  7
`define SCIR_MISC_ENC_HI  6
`define SCIR_MISC_ENC_LO  5
`define SCIR_MISC_ABRTUND 2
`define SCIR_MODE_SDLC    2'b10
`define SCIR_MODE_SYNC    2'b00
`define SCIR_ENC_NRZI     2'b01

// ----------------------------------------------------------------
// Commands, codes, reset values, timing
// ----------------------------------------------------------------
`define SCIR_CMD_CHB      2'b01
`define SCIR_CMD_CHA      2'b10
`define SCIR_CMD_HW       2'b11
`define SCIR_CODE_NONE    3'b011
`define SCIR_REG_RST      8'h00
`define SCIR_CRC_RESIDUE  16'h1d0f
`define SCIR_DEACT_PCLK   4
`define SCIR_DEACT_CYC    3'h4

`endif

// [rtl/scir_regs.v]
// Purpose: Control registers, master interrupt and daisy chain
//          logic of a two-channel serial controller
// Assumes: i_sys_clk is the peripheral clock; channel index 1 is A,
//          index 0 is B; serial engines sit outside this block
// Notes  : Vector bus, chain and request pins are active low where
//          named _n; chain input and acknowledge pins are synced
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "scir_consts.vh"

module scir_regs (
	input  wire        i_sys_clk,
	input  wire        i_rst,
	input  wire [4:0]  i_addr,
	input  wire [7:0]  i_wdata,
	input  wire        i_wr,
	input  wire        i_rd,
	output reg  [7:0]  o_rdata,
	input  wire [15:0] i_stat0,
	input  wire [15:0] i_stat1,
	input  wire [15:0] i_stat10,
	input  wire [15:0] i_stat13,
	input  wire [7:0]  i_pend_set,
	input  wire [7:0]  i_pend_clr,
	input  wire        i_ius_clr,
	input  wire [1:0]  i_flag_end,
	input  wire [1:0]  i_tx_req,
	input  wire [1:0]  i_req_mode,
	input  wire        i_chain_enable_in,
	input  wire        i_irq_ack_cycle,
	output reg         o_int_n,
	output reg         o_chain_enable_out,
	output reg  [7:0]  o_vec_data,
	output reg         o_vec_oe_n,
	output reg  [1:0]  o_chan_rst,
	output reg  [7:0]  o_wr_data,
	output reg  [1:0]  o_txbuf_wr,
	output reg  [1:0]  o_sync_wr,
	output reg  [1:0]  o_txd_force_hi,
	output reg  [1:0]  o_rts_n,
	output reg  [1:0]  o_dtr_req_n,
	output reg  [1:0]  o_rx_crc_full,
	output reg  [1:0]  o_auto_eom,
	output reg  [1:0]  o_auto_flag,
	output reg  [1:0]  o_crc_preset_ones,
	output reg  [1:0]  o_crc_sdlc,
	output reg  [3:0]  o_encoding,
	output reg  [1:0]  o_rx_en,
	output reg  [1:0]  o_tx_en
);

// ----------------------------------------------------------------
// Functions
// ----------------------------------------------------------------
// Highest set bit, valid flag on top
function [3:0] f_top;
	input [7:0] v;
	integer     k;
	begin
		f_top = 4'h0;
		for (k = 0; k < 8; k = k + 1) begin
			if (v[k]) begin
				f_top = {1'b1, k[2:0]};
			end
		end
	end
endfunction

// Insert the source code at the high or low vector position
function [7:0] f_vec;
	input [7:0] base;
	input [2:0] code;
	input       hi;
	begin
		if (hi) begin
			f_vec = {base[7], code, base[3:0]};
		end else begin
			f_vec = {base[7:4], code, base[0]};
		end
	end
endfunction

// Byte of a channel pair, A in the high byte
function [7:0] f_byte;
	input [15:0] v;
	input        ch;
	begin
		f_byte = ch ? v[15:8] : v[7:0];
	end
endfunction

// Write to a given register of a given channel
function f_wr;
	input [4:0] a;
	input       wr;
	input       ch;
	input [3:0] r;
	begin
		f_wr = wr & (a[4] == ch) & (a[3:0] == r);
	end
endfunction

// ----------------------------------------------------------------
// Storage
// ----------------------------------------------------------------
reg [7:0] rxp  [0:1];
reg [7:0] mode [0:1];
reg [7:0] txp  [0:1];
reg [7:0] extf [0:1];
reg [7:0] misc [0:1];
reg [7:0] sie  [0:1];
reg [7:0] vec_base;
reg [7:0] mic;
reg [7:0] pend;
reg [7:0] in_service_latch;
reg [1:0] rts_hold;
reg [1:0] req_blk;
reg [2:0] req_cnt  [0:1];
reg       iei_m;
reg       iei_s;
reg       ack_m;
reg       ack_s;
reg       ack_d;
reg       vec_drv;

reg [1:0] rst_ch;
reg       hw_soft;
reg [7:0] clr_mask;
reg [7:0] elig;
reg [3:0] top_ius;
reg [3:0] top_elig;
reg [2:0] code;
reg       int_req;
reg       ack_now;
reg       hw_ack;
reg [7:0] next_ius_set;
reg [7:0] next_rdata;
reg [1:0] sdlc;
reg [1:0] async_mode;
reg [1:0] auto_rts;
reg [1:0] tx_drop;
integer   c;

// ----------------------------------------------------------------
// Decode of commands, priorities and mode qualifiers
// ----------------------------------------------------------------
// One master register answers at slot 9 of either channel
always @* begin
	rst_ch  = 2'b00;
	hw_soft = 1'b0;
	if (i_wr && i_addr[3:0] == `SCIR_AD_MIC_RXPX) begin // RULE_11
		case (i_wdata[`SCIR_MIC_RST_HI:`SCIR_MIC_RST_LO]) // RULE_12
		`SCIR_CMD_CHB: rst_ch = 2'b01;
		`SCIR_CMD_CHA: rst_ch = 2'b10;
		`SCIR_CMD_HW: begin
			rst_ch  = 2'b11;
			hw_soft = 1'b1;
		end
		default: rst_ch = 2'b00;
		endcase
	end
	clr_mask = {{4{rst_ch[1]}}, {4{rst_ch[0]}}}; // RULE_13
	top_ius  = f_top(in_service_latch);
	for (c = 0; c < 8; c = c + 1) begin
		elig[c] = pend[c] & (~top_ius[3] | (c > top_ius[2:0]));
	end
	top_elig = f_top(elig);
	code     = top_elig[3] ? top_elig[2:0] : `SCIR_CODE_NONE;
	// No request without master enable, so no new in-service
	int_req  = mic[`SCIR_MIC_MIE] & iei_s & top_elig[3]; // RULE_17
	hw_ack   = ack_s & ~ack_d & int_req;
	ack_now  = hw_ack | (i_rd & (i_addr[3:0] == `SCIR_AD_VEC) &
		mic[`SCIR_MIC_SWACK] & int_req); // RULE_15
	next_ius_set = ack_now ? (8'h01 << top_elig[2:0]) : 8'h00;
	for (c = 0; c < 2; c = c + 1) begin
		sdlc[c] = (mode[c][5:4] == `SCIR_MODE_SDLC) &&
			(mode[c][3:2] == `SCIR_MODE_SYNC);
		async_mode[c] = (mode[c][3:2] != `SCIR_MODE_SYNC);
		auto_rts[c] = sdlc[c] & ~misc[c][`SCIR_MISC_ABRTUND] &
			extf[c][`SCIR_EXTF_AUTORTS]; // RULE_08
		tx_drop[c] = extf[c][`SCIR_EXTF_FORCEHI] & sdlc[c] &
			(misc[c][`SCIR_MISC_ENC_HI:`SCIR_MISC_ENC_LO] ==
			`SCIR_ENC_NRZI); // RULE_07
	end
end

// ----------------------------------------------------------------
// Read multiplexer
// ----------------------------------------------------------------
// Extended read swaps five slots to the written values
always @* begin
	next_rdata = `SCIR_REG_RST;
	case (i_addr[3:0])
	`SCIR_AD_STAT0: next_rdata = f_byte(i_stat0, i_addr[4]);
	`SCIR_AD_STAT1: next_rdata = f_byte(i_stat1, i_addr[4]);
	`SCIR_AD_VEC: begin
		// Channel A reads the raw vector, B the modified one
		if (i_addr[4]) begin
			next_rdata = vec_base;
		end else begin
			next_rdata = f_vec(vec_base, code,
				mic[`SCIR_MIC_STATHI]); // RULE_16
		end
	end
	`SCIR_AD_RXP_PEND: next_rdata = i_addr[4] ? pend : `SCIR_REG_RST;
	`SCIR_AD_MODE: begin
		next_rdata = extf[i_addr[4]][`SCIR_EXTF_RDEXT] ?
			mode[i_addr[4]] : f_byte(i_stat0, i_addr[4]); // RULE_02
	end
	`SCIR_AD_TXP: begin
		next_rdata = extf[i_addr[4]][`SCIR_EXTF_RDEXT] ?
			txp[i_addr[4]] : f_byte(i_stat1, i_addr[4]); // RULE_02
	end
	`SCIR_AD_MIC_RXPX: begin
		next_rdata = extf[i_addr[4]][`SCIR_EXTF_RDEXT] ?
			rxp[i_addr[4]] : f_byte(i_stat13, i_addr[4]); // RULE_02
	end
	`SCIR_AD_MISC_ST10: next_rdata = f_byte(i_stat10, i_addr[4]);
	`SCIR_AD_MISCX: begin
		next_rdata = extf[i_addr[4]][`SCIR_EXTF_RDEXT] ?
			misc[i_addr[4]] : sie[i_addr[4]]; // RULE_02
	end
	`SCIR_AD_STAT13: next_rdata = f_byte(i_stat13, i_addr[4]);
	`SCIR_AD_EXTF: begin
		next_rdata = extf[i_addr[4]][`SCIR_EXTF_RDEXT] ?
			extf[i_addr[4]] : f_byte(i_stat10, i_addr[4]); // RULE_02
	end
	`SCIR_AD_SIE: next_rdata = sie[i_addr[4]];
	default: next_rdata = `SCIR_REG_RST;
	endcase
end

// ----------------------------------------------------------------
// Interrupt latches, master register, daisy chain, vector bus
// ----------------------------------------------------------------
// Pin inputs pass two flops before the acknowledge edge detector
always @(posedge i_sys_clk) begin
	if (i_rst) begin
		iei_m              <= 1'b0;
		iei_s              <= 1'b0;
		ack_m              <= 1'b0;
		ack_s              <= 1'b0;
		ack_d              <= 1'b0;
		mic                <= `SCIR_REG_RST;
		vec_base           <= `SCIR_REG_RST;
		pend               <= 8'h00;
		in_service_latch                <= 8'h00;
		vec_drv            <= 1'b0;
		o_vec_data         <= 8'h00;
		o_vec_oe_n         <= 1'b1;
		o_int_n            <= 1'b1;
		o_chain_enable_out <= 1'b0;
		o_rdata            <= 8'h00;
	end else begin
		iei_m <= i_chain_enable_in;
		iei_s <= iei_m;
		ack_m <= i_irq_ack_cycle;
		ack_s <= ack_m;
		ack_d <= ack_s;
		// Control bits change only on writes; full reset keeps
		// enable, status position and chain disable as written
		if (hw_soft) begin
			mic <= i_wdata & `SCIR_MIC_KEEP; // RULE_12
		end else if (i_wr && i_addr[3:0] == `SCIR_AD_MIC_RXPX) begin
			mic <= i_wdata & `SCIR_MIC_STORE; // RULE_11
		end
		if (hw_soft) begin
			vec_base <= `SCIR_REG_RST;
		end else if (i_wr && i_addr[3:0] == `SCIR_AD_VEC) begin
			vec_base <= i_wdata;
		end
		// Set beats clear; a channel reset beats both
		pend <= ((pend & ~i_pend_clr) | i_pend_set) & ~clr_mask;
		in_service_latch  <= (in_service_latch & ~((i_ius_clr && top_ius[3]) ?
			(8'h01 << top_ius[2:0]) : 8'h00) | next_ius_set) &
			~clr_mask; // RULE_13
		// Vector stays on the bus while the acknowledge lasts
		vec_drv <= ack_s & (vec_drv | hw_ack);
		if (hw_ack) begin
			o_vec_data <= (mic[`SCIR_MIC_VIS] && !mic[`SCIR_MIC_NV]) ?
				f_vec(vec_base, code, mic[`SCIR_MIC_STATHI]) :
				vec_base; // RULE_20
		end
		o_vec_oe_n <= ~(ack_s & (vec_drv | hw_ack) &
			~mic[`SCIR_MIC_NV]); // RULE_19
		o_int_n <= ~int_req | ack_now; // RULE_15
		o_chain_enable_out <= iei_s & ~mic[`SCIR_MIC_DLC] & // RULE_18
			~(|in_service_latch) & ~(mic[`SCIR_MIC_MIE] & (|pend)) &
			~ack_now; // RULE_17
		o_rdata <= i_rd ? next_rdata : 8'h00;
	end
end

// ----------------------------------------------------------------
// Per-channel registers and pins
// ----------------------------------------------------------------
// Resets clear the channel; the extended bits go with them too
always @(posedge i_sys_clk) begin
	if (i_rst) begin
		for (c = 0; c < 2; c = c + 1) begin
			rxp[c]     <= `SCIR_REG_RST;
			mode[c]    <= `SCIR_REG_RST;
			txp[c]     <= `SCIR_REG_RST;
			extf[c]    <= `SCIR_REG_RST;
			misc[c]    <= `SCIR_REG_RST;
			sie[c]     <= `SCIR_REG_RST;
			req_cnt[c] <= 3'h0;
		end
		rts_hold          <= 2'b00;
		req_blk           <= 2'b00;
		o_chan_rst        <= 2'b00;
		o_wr_data         <= 8'h00;
		o_txbuf_wr        <= 2'b00;
		o_sync_wr         <= 2'b00;
		o_txd_force_hi    <= 2'b00;
		o_rts_n           <= 2'b11;
		o_dtr_req_n       <= 2'b11;
		o_rx_crc_full     <= 2'b00;
		o_auto_eom        <= 2'b00;
		o_auto_flag       <= 2'b00;
		o_crc_preset_ones <= 2'b00;
		o_crc_sdlc        <= 2'b00;
		o_encoding        <= 4'h0;
		o_rx_en           <= 2'b00;
		o_tx_en           <= 2'b00;
	end else begin
		o_chan_rst <= rst_ch; // RULE_13
		o_wr_data  <= i_wdata;
		for (c = 0; c < 2; c = c + 1) begin
			o_txbuf_wr[c] <= f_wr(i_addr, i_wr, c[0], `SCIR_AD_TXBUF) &
				~tx_drop[c]; // RULE_07
			o_sync_wr[c] <= f_wr(i_addr, i_wr, c[0], `SCIR_AD_SYNC) &
				~sie[c][`SCIR_SIE_EXTSEL];
			if (rst_ch[c]) begin
				// Receiver, transmitter, modem lines and presets off
				rxp[c][`SCIR_RXP_RXEN]     <= 1'b0; // RULE_13
				txp[c]                     <= `SCIR_REG_RST;
				extf[c]                    <= `SCIR_REG_RST; // RULE_03
				misc[c][`SCIR_MISC_PRESET] <= 1'b0;
				rts_hold[c]                <= 1'b0;
				req_blk[c]                 <= 1'b0;
				req_cnt[c]                 <= 3'h0;
				if (hw_soft) begin
					mode[c] <= `SCIR_REG_RST;
					misc[c] <= `SCIR_REG_RST; // RULE_22
					sie[c]  <= `SCIR_REG_RST;
				end
			end else begin
				if (f_wr(i_addr, i_wr, c[0], `SCIR_AD_RXP_PEND)) begin
					rxp[c] <= i_wdata;
				end
				if (f_wr(i_addr, i_wr, c[0], `SCIR_AD_MODE)) begin
					mode[c] <= i_wdata;
				end
				if (f_wr(i_addr, i_wr, c[0], `SCIR_AD_TXP)) begin
					txp[c] <= i_wdata;
				end
				// Register 7 lands in the extended bits while selected
				if (f_wr(i_addr, i_wr, c[0], `SCIR_AD_SYNC) &&
					sie[c][`SCIR_SIE_EXTSEL]) begin // RULE_01
					extf[c] <= i_wdata & `SCIR_EXTF_MASK; // RULE_04
				end
				if (f_wr(i_addr, i_wr, c[0], `SCIR_AD_MISC_ST10)) begin
					misc[c] <= i_wdata;
				end
				if (f_wr(i_addr, i_wr, c[0], `SCIR_AD_SIE)) begin
					sie[c] <= i_wdata;
				end
				// With auto RTS on, pin stays asserted until the closing flag ends
				if (txp[c][`SCIR_TXP_RTS]) begin
					rts_hold[c] <= 1'b1;
				end else if (!auto_rts[c] || i_flag_end[c]) begin
					rts_hold[c] <= 1'b0; // RULE_08
				end
				// Request drops on a buffer write, fast or delayed
				if (!i_tx_req[c]) begin
					req_blk[c] <= 1'b0;
					req_cnt[c] <= 3'h0;
				end else if (f_wr(i_addr, i_wr, c[0], `SCIR_AD_TXBUF)) begin
					if (extf[c][`SCIR_EXTF_CRCFULL]) begin
						req_blk[c] <= 1'b1; // RULE_06
					end else begin
						req_cnt[c] <= `SCIR_DEACT_CYC; // RULE_06
					end
				end else if (req_cnt[c] != 3'h0) begin
					req_cnt[c] <= req_cnt[c] - 3'h1;
					if (req_cnt[c] == 3'h1) begin
						req_blk[c] <= 1'b1;
					end
				end
			end
			o_rts_n[c] <= ~(txp[c][`SCIR_TXP_RTS] | rts_hold[c]);
			o_dtr_req_n[c] <= i_req_mode[c] ?
				~(i_tx_req[c] & ~req_blk[c]) : ~txp[c][`SCIR_TXP_DTR];
			o_txd_force_hi[c] <= tx_drop[c]; // RULE_07
			o_rx_crc_full[c] <= extf[c][`SCIR_EXTF_CRCFULL]; // RULE_05
			o_auto_eom[c] <= extf[c][`SCIR_EXTF_AUTOEOM]; // RULE_09
			o_auto_flag[c] <= extf[c][`SCIR_EXTF_AUTOFLG]; // RULE_10
			// Preset has no meaning to the asynchronous engine
			o_crc_preset_ones[c] <= misc[c][`SCIR_MISC_PRESET] &
				~async_mode[c]; // RULE_21
			o_crc_sdlc[c] <= sdlc[c]; // RULE_21
			o_rx_en[c] <= rxp[c][`SCIR_RXP_RXEN];
			o_tx_en[c] <= txp[c][`SCIR_TXP_TXEN];
		end
		o_encoding <= {misc[1][`SCIR_MISC_ENC_HI:`SCIR_MISC_ENC_LO],
			misc[0][`SCIR_MISC_ENC_HI:`SCIR_MISC_ENC_LO]}; // RULE_22
	end
end

endmodule // scir_regs

// [verif/scir_regs_properties.sv]
// Purpose: Port-level assertions for the serial control register bank
// Assumes: Bound to scir_regs; shadow state mirrors the master register
// Notes  : Derived outputs land one cycle after the register update
`timescale 1ns/1ps

module scir_chk (
	input wire       i_sys_clk,
	input wire       i_rst,
	input wire [4:0] i_addr,
	input wire [7:0] i_wdata,
	input wire       i_wr,
	input wire       i_rd,
	input wire [7:0] o_rdata,
	input wire       o_int_n,
	input wire       o_chain_enable_out,
	input wire       o_vec_oe_n,
	input wire [1:0] o_chan_rst,
	input wire [1:0] o_sync_wr,
	input wire [1:0] o_rts_n,
	input wire [1:0] o_tx_en,
	input wire [1:0] o_rx_en,
	input wire [3:0] o_encoding
);
	// ----------------------------------------
	// Shadow state
	// ----------------------------------------
	wire [3:0] rn  = i_addr[3:0];
	wire       wr9 = i_wr && rn == 4'h9;
	reg  [5:0] mic;
	reg  [1:0] sie;

	// Full reset command keeps only enable, position and chain bits
	always @(posedge i_sys_clk) begin
		if (i_rst) begin
			mic <= 6'h00;
			sie <= 2'b00;
		end else if (wr9 && i_wdata[7:6] == 2'b11) begin
			mic <= i_wdata[5:0] & 6'h1c;
			sie <= 2'b00;
		end else if (wr9) begin
			mic <= i_wdata[5:0];
		end else if (i_wr && rn == 4'hf) begin
			sie[i_addr[4]] <= i_wdata[0];
		end
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);

	chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data outside its slot");
	chk_ext_redirect: assert property (
		i_wr && rn == 4'h7 && sie[i_addr[4]] |=> (o_sync_wr == 2'b00) [*2])
		else $error("sync write while extended select set");
	chk_sync_write: assert property (
		i_wr && i_addr == 5'h07 && !sie[0] |-> ##[1:2] o_sync_wr[0])
		else $error("sync write missing");
	chk_rst_chan_b: assert property (
		wr9 && i_wdata[7:6] == 2'b01 |-> ##[1:2] o_chan_rst == 2'b01)
		else $error("channel B reset pulse wrong");
	chk_rst_chan_a: assert property (
		wr9 && i_wdata[7:6] == 2'b10 |-> ##[1:2] o_chan_rst == 2'b10)
		else $error("channel A reset pulse wrong");
	chk_rst_disable: assert property (wr9 && i_wdata[7:6] == 2'b10 |->
		##3 (o_rts_n[1] && o_tx_en[1] == 1'b0 && o_rx_en[1] == 1'b0))
		else $error("channel A still active after reset");
	chk_full_nrz: assert property (wr9 && i_wdata[7:6] == 2'b11 |->
		##3 (o_encoding == 4'h0 && o_int_n))
		else $error("full reset left encoding or request");
	chk_hw_nrz: assert property ($past(i_rst) |-> o_encoding == 4'h0)
		else $error("encoding not NRZ after reset");
	chk_rts_follow: assert property (
		i_wr && i_addr == 5'h15 && i_wdata[1] |-> ##2 !o_rts_n[1])
		else $error("request-to-send pin did not follow");
	chk_chain_dlc: assert property (
		mic[2] && $past(mic[2]) |-> !o_chain_enable_out)
		else $error("chain output high with lower chain off");
	chk_mie_gate: assert property (!mic[3] && !$past(mic[3]) |-> o_int_n)
		else $error("interrupt with master enable clear");
	chk_nv_bus: assert property (mic[1] && $past(mic[1]) |-> o_vec_oe_n)
		else $error("vector driven with no-vector set");
	chk_soft_ack: assert property (i_rd && rn == 4'h2 && mic[5] &&
		mic[3] && !o_int_n |-> ##2 (o_int_n && !o_chain_enable_out))
		else $error("soft acknowledge had no effect");

	cov_soft_ack: cover property (i_rd && rn == 4'h2 && mic[5]);
	cov_chan_rst: cover property (o_chan_rst != 2'b00);
	cov_vec_drive: cover property (!o_vec_oe_n);
endmodule // scir_chk

// [verif/scir_far.sv]
// Purpose: Upstream daisy-chain neighbour and acknowledge pin source
// Assumes: An acknowledge request arrives as a one-cycle pulse
// Notes  : The neighbour never claims the chain for itself
`timescale 1ns/1ps

module scir_far (
	input  wire i_sys_clk,
	input  wire i_rst,
	input  wire i_go,
	output reg  o_chain_in,
	output reg  o_ack
);
	reg [3:0] left;

	// ----------------------------------------
	// Acknowledge cycle
	// ----------------------------------------
	// Pin held ten cycles so the synchroniser sees a clean edge
	always @(posedge i_sys_clk) begin
		if (i_rst) begin
			left <= 4'h0;
			o_ack <= 1'b0;
			o_chain_in <= 1'b0;
		end else begin
			o_chain_in <= 1'b1;
			if (i_go)
				left <= 4'ha;
			else if (left != 4'h0)
				left <= left - 4'h1;
			o_ack <= i_go || (left > 4'h1);
		end
	end
endmodule // scir_far

// [verif/scir_regs_test.sv]
// Purpose: Self-checking bench for the serial control register bank
// Assumes: One-cycle bus strobes, 200 MHz clock
// Notes  : Flag-end and request pins are held idle
`timescale 1ns/1ps

module scir_regs_test;
	reg         i_sys_clk;
	reg         i_rst;
	reg  [4:0]  i_addr;
	reg  [7:0]  i_wdata;
	reg         i_wr;
	reg         i_rd;
	reg  [15:0] i_stat0, i_stat1, i_stat10, i_stat13;
	reg  [7:0]  i_pend_set, i_pend_clr;
	reg         i_ius_clr;
	reg         ack_go;
	wire        chain_in, ack_pin, o_int_n, o_chain_enable_out, o_vec_oe_n;
	wire [7:0]  o_rdata, o_vec_data;
	wire [1:0]  o_chan_rst, o_txbuf_wr, o_sync_wr, o_txd_force_hi, o_rts_n;
	wire [1:0]  o_crc_preset_ones, o_rx_en, o_tx_en, o_crc_sdlc;
	wire [1:0]  o_rx_crc_full, o_auto_eom, o_auto_flag;
	wire [3:0]  o_encoding;
	int         num_errors, checked, cycles, k;
	logic [7:0] q, base, e, v [4], ex [5];
	logic       hi;
	logic [3:0] slot [5] = '{4'h9, 4'h4, 4'h5, 4'he, 4'hb};

	scir_regs i_dut (
		.i_sys_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
		.i_stat0, .i_stat1, .i_stat10, .i_stat13, .i_pend_set, .i_pend_clr,
		.i_ius_clr, .i_flag_end(2'b00), .i_tx_req(2'b00), .i_req_mode(2'b00),
		.i_chain_enable_in(chain_in), .i_irq_ack_cycle(ack_pin), .o_int_n,
		.o_chain_enable_out, .o_vec_data, .o_vec_oe_n, .o_chan_rst,
		.o_wr_data(), .o_txbuf_wr, .o_sync_wr, .o_txd_force_hi, .o_rts_n,
		.o_dtr_req_n(), .o_rx_crc_full, .o_auto_eom, .o_auto_flag,
		.o_crc_preset_ones, .o_crc_sdlc, .o_encoding, .o_rx_en, .o_tx_en);

	scir_far i_far (.i_sys_clk, .i_rst, .i_go(ack_go), .o_chain_in(chain_in),
		.o_ack(ack_pin));

	// ----------------------------------------
	// Clock, timeout and helpers
	// ----------------------------------------
	always #2.5 i_sys_clk = ~i_sys_clk;

	// Run needs about 330 cycles; a hang ends as a failure
	always @(posedge i_sys_clk) begin
		cycles = cycles + 1;
		if (cycles == 8000) begin
			num_errors = num_errors + 1;
			conclude();
		end
	end

	task automatic conclude();
		if (num_errors == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] want);
		checked = checked + 1;
		if (seen !== want) begin
			num_errors = num_errors + 1;
			$display("unexpected at %0t: saw %h want %h", $time, seen, want);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge i_sys_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
	endtask

	// Read data only stand in the cycle after the strobe
	task automatic rd(input logic [4:0] a, output logic [7:0] d);
		@(posedge i_sys_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask

	task automatic pulse(input logic [7:0] s, input logic [7:0] c);
		@(posedge i_sys_clk);
		i_pend_set <= s;
		i_pend_clr <= c;
		i_ius_clr <= (c != 8'h00);
		@(posedge i_sys_clk);
		i_pend_set <= 8'h00;
		i_pend_clr <= 8'h00;
		i_ius_clr <= 1'b0;
	endtask

	// Transmit buffer write, watching three cycles for the engine pulse
	task automatic txw(input logic want);
		logic s;
		s = 1'b0;
		wr(5'h08, 8'($urandom));
		repeat (3) begin
			#1 s = s | o_txbuf_wr[0];
			@(posedge i_sys_clk);
		end
		chk({7'h00, s}, {7'h00, want});
	endtask

	function automatic logic [7:0] vec_exp(input logic [7:0] b,
		input logic [2:0] c, input logic h);
		vec_exp = h ? {b[7], c, b[3:0]} : {b[7:4], c, b[0]};
	endfunction

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{i_sys_clk, i_wr, i_rd, i_ius_clr, ack_go} = 5'b00000;
		{i_addr, i_wdata, i_pend_set, i_pend_clr} = 29'h0;
		{i_stat0, i_stat1, i_stat10, i_stat13} = 64'h0;
		{num_errors, checked, cycles} = 3'b000;
		i_rst = 1'b1;
		void'($urandom(32'h41da8dd9));
		repeat (5) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		i_stat0 <= 16'($urandom);
		i_stat1 <= 16'($urandom);
		i_stat10 <= 16'($urandom);
		i_stat13 <= 16'($urandom);
		// Slot swap on channel B with extended read off, then on
		wr(5'h0f, 8'h01);
		for (k = 0; k < 4; k++) begin
			v[k] = 8'($urandom);
			wr({1'b0, k == 0 ? 4'h3 : (k == 3 ? 4'ha : slot[k])}, v[k]);
		end
		ex = '{i_stat13[7:0], i_stat0[7:0], i_stat1[7:0], i_stat10[7:0], 8'h01};
		for (k = 0; k < 5; k++) begin
			rd({1'b0, slot[k]}, q);
			chk(q, ex[k]);
		end
		e = {2'b01, 6'($urandom) & 6'h37};
		wr(5'h07, e);
		ex = '{v[0], v[1], v[2], e, v[3]};
		for (k = 0; k < 5; k++) begin
			rd({1'b0, slot[k]}, q);
			chk(q, ex[k]);
		end
		chk({7'h00, o_rx_crc_full[0]}, {7'h00, e[5]});
		chk({7'h00, o_auto_eom[0]}, {7'h00, e[1]});
		chk({7'h00, o_auto_flag[0]}, {7'h00, e[0]});
		wr(5'h0f, 8'h00);
		wr(5'h07, 8'h7e);
		rd(5'h0e, q);
		chk(q, e);
		wr(5'h09, 8'h40);
		cyc(5);
		rd(5'h0e, q);
		chk(q, i_stat10[7:0]);
		// Forced line high drops transmit buffer writes
		wr(5'h0f, 8'h01);
		wr(5'h04, 8'h20);
		wr(5'h0a, 8'h20);
		wr(5'h07, 8'h08);
		cyc(2);
		chk({7'h00, o_txd_force_hi[0]}, 8'h01);
		chk({7'h00, o_crc_sdlc[0]}, 8'h01);
		txw(1'b0);
		wr(5'h07, 8'h00);
		txw(1'b1);
		// Every reset command against both enabled channels
		for (k = 0; k < 4; k++) begin
			wr(5'h15, 8'h0a);
			wr(5'h05, 8'h0a);
			wr(5'h13, 8'h01);
			wr(5'h03, 8'h01);
			wr(5'h09, {k[1:0], 6'h00});
			cyc(5);
			chk({6'h00, o_tx_en}, {6'h00, ~k[1:0]});
			chk({6'h00, o_rx_en}, {6'h00, ~k[1:0]});
			chk({6'h00, o_rts_n}, {6'h00, k[1:0]});
		end
		// Vector base, then soft acknowledge of each source code
		base = 8'($urandom);
		wr(5'h02, base);
		rd(5'h12, q);
		chk(q, base);
		for (k = 0; k < 8; k++) begin
			hi = 1'($urandom);
			wr(5'h09, {3'b001, hi, 4'b1001});
			pulse(8'h01 << k, 8'h00);
			cyc(3);
			chk({7'h00, o_int_n}, 8'h00);
			rd(5'h02, q);
			chk(q, vec_exp(base, k[2:0], hi));
			cyc(2);
			chk({7'h00, o_int_n}, 8'h01);
			pulse(8'h00, 8'h01 << k);
		end
		// Hardware acknowledge with and without the no-vector bit
		for (k = 0; k < 2; k++) begin
			wr(5'h09, {6'h02, k[0], 1'b1});
			pulse(8'h20, 8'h00);
			cyc(3);
			@(posedge i_sys_clk);
			ack_go <= 1'b1;
			@(posedge i_sys_clk);
			ack_go <= 1'b0;
			cyc(6);
			chk({7'h00, o_vec_oe_n}, {7'h00, k[0]});
			if (k == 0)
				chk(o_vec_data, vec_exp(base, 3'h5, 1'b0));
			cyc(12);
			pulse(8'h00, 8'h20);
		end
		// Lower chain disable, then chain output follows its input
		wr(5'h09, 8'h04);
		cyc(4);
		chk({7'h00, o_chain_enable_out}, 8'h00);
		wr(5'h09, 8'h00);
		cyc(4);
		chk({7'h00, o_chain_enable_out}, 8'h01);
		// Each encoding and both CRC presets on channel A
		for (k = 0; k < 4; k++) begin
			wr(5'h1a, {k[0], k[1:0], 5'h00});
			cyc(2);
			chk({4'h0, o_encoding}, {4'h0, k[1:0], 2'b00});
			chk({7'h00, o_crc_preset_ones[1]}, {7'h00, k[0]});
		end
		wr(5'h09, 8'hc0);
		cyc(5);
		chk({4'h0, o_encoding}, 8'h00);
		conclude();
	end
endmodule // scir_regs_test

bind scir_regs scir_chk u_chk (.i_sys_clk, .i_rst, .i_addr, .i_wdata, .i_wr,
	.i_rd, .o_rdata, .o_int_n, .o_chain_enable_out, .o_vec_oe_n, .o_chan_rst,
	.o_sync_wr, .o_rts_n, .o_tx_en, .o_rx_en, .o_encoding);
